// [inc/aasa_map.svh]
// Constants for the add-and-shift ALU: register offsets, status bits, opcode fields.
// Assumes inclusion by bare name from the package and the design files.
`ifndef AASA_MAP_SVH
`define AASA_MAP_SVH

// Register offsets on the plain register port
`define AASA_OFS_W 4'h0
`define AASA_OFS_STATUS 4'h1
`define AASA_OFS_PTR0_LO 4'h2
`define AASA_OFS_PTR0_HI 4'h3
`define AASA_OFS_PTR1_LO 4'h4
`define AASA_OFS_PTR1_HI 4'h5

// Status bit positions and reset values
`define AASA_ST_C 0
`define AASA_ST_DC 1
`define AASA_ST_Z 2
`define AASA_RST_W 8'h00
`define AASA_RST_STATUS 3'h0
`define AASA_RST_PTR 16'h0000
`define AASA_RST_BYTE 8'h00
`define AASA_RST_ADDR 7'h00

// Instruction fields
`define AASA_PTR_PREFIX 7'h62
`define AASA_PTR_SEL_BIT 6
`define AASA_PTR_K_MSB 5
`define AASA_DEST_BIT 7
`define AASA_ZERO_BYTE 8'h00

// Six-bit opcode prefixes in instr[13:8]
`define AASA_OP_ADD_FILE 6'h07
`define AASA_OP_AND_FILE 6'h05
`define AASA_OP_ADD_FILE_C 6'h3d
`define AASA_OP_ASR_FILE 6'h37
`define AASA_OP_ADD_IMM 6'h3e
`define AASA_OP_AND_IMM 6'h39

`endif

// [inc/aasa_pkg.sv]
// Types for the add-and-shift ALU.
// Assumes aasa_map.svh is on the include path.
package aasa_pkg;
  `include "aasa_map.svh"

  typedef enum logic [2:0] {
    AASA_OP_NONE,
    AASA_OP_ADDI,
    AASA_OP_ANDI,
    AASA_OP_ADDF,
    AASA_OP_ADDFC,
    AASA_OP_ANDF,
    AASA_OP_ARITH_SHIFT_RIGHT_FILE,
    AASA_OP_PTR
  } aasa_op_type;

  typedef enum logic [1:0] {
    AASA_ST_IDLE,
    AASA_ST_WAIT,
    AASA_ST_EXEC
  } aasa_state_type;
endpackage

// [inc/aasa_add_if.sv]
// Operand and result bundle between the ALU and its byte adder.
// Assumes both ends sit in the same clock domain; purely combinational.
`timescale 1ns/100ps
interface aasa_add_if;
  logic [7:0] a;
  logic [7:0] b;
  logic cin;
  logic [7:0] sum;
  logic carry;
  logic digit_carry;

  modport alu (output a, output b, output cin, input sum, input carry, input digit_carry);
  modport adder (input a, input b, input cin, output sum, output carry, output digit_carry);
endinterface

// [rtl/aasa_adder.sv]
// Byte adder with carry out of bit 3 and bit 7.
// Assumes the ALU drives operands through aasa_add_if.
`timescale 1ns/100ps
module aasa_adder (
  aasa_add_if.adder add
);
  logic [4:0] lo;
  logic [4:0] hi;

  always_comb begin
    lo = {1'b0, add.a[3:0]} + {1'b0, add.b[3:0]} + {4'h0, add.cin};
    hi = {1'b0, add.a[7:4]} + {1'b0, add.b[7:4]} + {4'h0, lo[4]};
    add.sum = {hi[3:0], lo[3:0]};
    add.digit_carry = lo[4]; // RULE11
    add.carry = hi[4]; // RULE11
  end
endmodule

// [rtl/aasa_alu.sv]
// Execution datapath for add, AND, shift and pointer-add instructions.
// Assumes a data memory with a one-cycle read latency on o_mem_rd and
// a decoder that presents one 14-bit instruction word with a valid pulse.
//
// Function
// [RULE1] Pointer add sign-extends a 6-bit literal into the chosen pointer; flags untouched.
// [RULE2] Pointer sums wrap modulo 65536 at both ends.
// [RULE3] AND immediate: W AND literal into W, only zero flag changes.
// [RULE4] Add immediate: W plus literal into W, carry, digit carry, zero change.
// [RULE5] AND file: W AND memory byte to destination, only zero flag changes.
// [RULE6] Add file: W plus memory byte to destination, all three flags change.
// [RULE7] Destination bit 0 writes W, destination bit 1 writes the file byte.
// [RULE8] Arithmetic shift right keeps bit 7, old bit 0 to carry, zero updated.
// [RULE9] Add with carry: W, memory byte and carry summed to destination, flags updated.
// [RULE10] Pointer add decodes from 11 0001 0nkk kkkk; n picks pointer, k literal.
// [RULE11] Zero on all-zero result; carry from bit 7; digit carry from bit 3.
`timescale 1ns/100ps
`include "aasa_map.svh"
module aasa_alu
  import aasa_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Instruction issue
  input wire logic i_instr_valid,
  input wire logic [13:0] i_instr,
  output logic o_busy,
  // Data memory
  output logic o_mem_rd,
  output logic o_mem_wr,
  output logic [6:0] o_mem_addr,
  output logic [7:0] o_mem_wdata,
  input wire logic [7:0] i_mem_rdata,
  // Register port
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Core state
  output logic [7:0] o_w,
  output logic [2:0] o_status
);
  aasa_add_if add ();

  aasa_adder u_adder (
    .add(add)
  );

  aasa_state_type state_reg, state_next;
  aasa_op_type op_reg, op_next;
  logic dest_reg, dest_next;
  logic [7:0] w_reg, w_next;
  logic [2:0] status_reg, status_next;
  logic [15:0] ptr0_reg, ptr0_next;
  logic [15:0] ptr1_reg, ptr1_next;
  logic mem_rd_reg, mem_rd_next;
  logic mem_wr_reg, mem_wr_next;
  logic [6:0] mem_addr_reg, mem_addr_next;
  logic [7:0] mem_wdata_reg, mem_wdata_next;
  logic [7:0] rdata_reg, rdata_next;

  aasa_op_type op_dec;
  logic [15:0] ptr_step;
  logic [7:0] result;

  // Decode of the incoming word
  always_comb begin
    op_dec = AASA_OP_NONE;
    if (i_instr[13:7] == `AASA_PTR_PREFIX) begin
      op_dec = AASA_OP_PTR; // RULE10
    end else begin
      unique case (i_instr[13:8])
        `AASA_OP_ADD_FILE: op_dec = AASA_OP_ADDF;
        `AASA_OP_AND_FILE: op_dec = AASA_OP_ANDF;
        `AASA_OP_ADD_FILE_C: op_dec = AASA_OP_ADDFC;
        `AASA_OP_ASR_FILE: op_dec = AASA_OP_ARITH_SHIFT_RIGHT_FILE;
        `AASA_OP_ADD_IMM: op_dec = AASA_OP_ADDI;
        `AASA_OP_AND_IMM: op_dec = AASA_OP_ANDI;
        default: op_dec = AASA_OP_NONE;
      endcase
    end
    ptr_step = {{10{i_instr[`AASA_PTR_K_MSB]}}, i_instr[`AASA_PTR_K_MSB:0]}; // RULE1
  end

  // Adder operands: literal while idle, memory byte while executing
  always_comb begin
    add.a = w_reg;
    add.b = (state_reg == AASA_ST_EXEC) ? i_mem_rdata : i_instr[7:0];
    add.cin = (state_reg == AASA_ST_EXEC) && (op_reg == AASA_OP_ADDFC) &&
              status_reg[`AASA_ST_C]; // RULE9
  end

  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    dest_next = dest_reg;
    w_next = w_reg;
    status_next = status_reg;
    ptr0_next = ptr0_reg;
    ptr1_next = ptr1_reg;
    mem_rd_next = 1'b0;
    mem_wr_next = 1'b0;
    mem_addr_next = mem_addr_reg;
    mem_wdata_next = mem_wdata_reg;
    rdata_next = rdata_reg;
    result = `AASA_ZERO_BYTE;

    // Software access; an instruction in the same cycle overrides below
    if (i_wr) begin
      unique case (i_addr)
        `AASA_OFS_W: w_next = i_wdata;
        `AASA_OFS_STATUS: status_next = i_wdata[2:0];
        `AASA_OFS_PTR0_LO: ptr0_next[7:0] = i_wdata;
        `AASA_OFS_PTR0_HI: ptr0_next[15:8] = i_wdata;
        `AASA_OFS_PTR1_LO: ptr1_next[7:0] = i_wdata;
        `AASA_OFS_PTR1_HI: ptr1_next[15:8] = i_wdata;
        default: ;
      endcase
    end
    if (i_rd) begin
      unique case (i_addr)
        `AASA_OFS_W: rdata_next = w_reg;
        `AASA_OFS_STATUS: rdata_next = {5'h00, status_reg};
        `AASA_OFS_PTR0_LO: rdata_next = ptr0_reg[7:0];
        `AASA_OFS_PTR0_HI: rdata_next = ptr0_reg[15:8];
        `AASA_OFS_PTR1_LO: rdata_next = ptr1_reg[7:0];
        `AASA_OFS_PTR1_HI: rdata_next = ptr1_reg[15:8];
        default: rdata_next = `AASA_ZERO_BYTE;
      endcase
    end

    unique case (state_reg)
      AASA_ST_IDLE: begin
        if (i_instr_valid) begin
          unique case (op_dec)
            AASA_OP_ADDI: begin
              w_next = add.sum; // RULE4
              status_next[`AASA_ST_C] = add.carry; // RULE4
              status_next[`AASA_ST_DC] = add.digit_carry; // RULE4
              status_next[`AASA_ST_Z] = (add.sum == `AASA_ZERO_BYTE); // RULE11
            end
            AASA_OP_ANDI: begin
              w_next = w_reg & i_instr[7:0]; // RULE3
              status_next[`AASA_ST_Z] = ((w_reg & i_instr[7:0]) == `AASA_ZERO_BYTE); // RULE3
            end
            AASA_OP_PTR: begin
              // Plain 16-bit sum drops the carry, so both ends wrap
              if (i_instr[`AASA_PTR_SEL_BIT]) begin
                ptr1_next = ptr1_reg + ptr_step; // RULE2
              end else begin
                ptr0_next = ptr0_reg + ptr_step; // RULE1
              end
            end
            AASA_OP_ADDF, AASA_OP_ADDFC, AASA_OP_ANDF, AASA_OP_ARITH_SHIFT_RIGHT_FILE: begin
              op_next = op_dec;
              dest_next = i_instr[`AASA_DEST_BIT];
              mem_addr_next = i_instr[6:0];
              mem_rd_next = 1'b1;
              state_next = AASA_ST_WAIT;
            end
            AASA_OP_NONE: ;
          endcase
        end
      end
      AASA_ST_WAIT: begin
        state_next = AASA_ST_EXEC;
      end
      AASA_ST_EXEC: begin
        unique case (op_reg)
          AASA_OP_ANDF: begin
            result = w_reg & i_mem_rdata; // RULE5
          end
          AASA_OP_ARITH_SHIFT_RIGHT_FILE: begin
            result = {i_mem_rdata[7], i_mem_rdata[7:1]}; // RULE8
            status_next[`AASA_ST_C] = i_mem_rdata[0]; // RULE8
          end
          default: begin
            result = add.sum; // RULE6 RULE9
            status_next[`AASA_ST_C] = add.carry; // RULE6 RULE9
            status_next[`AASA_ST_DC] = add.digit_carry; // RULE6 RULE9
          end
        endcase
        status_next[`AASA_ST_Z] = (result == `AASA_ZERO_BYTE); // RULE5 RULE8 RULE11
        if (dest_reg) begin
          mem_wr_next = 1'b1; // RULE7
          mem_wdata_next = result; // RULE7
        end else begin
          w_next = result; // RULE7
        end
        state_next = AASA_ST_IDLE;
      end
      default: state_next = AASA_ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg <= AASA_ST_IDLE;
      op_reg <= AASA_OP_NONE;
      dest_reg <= 1'b0;
      w_reg <= `AASA_RST_W;
      status_reg <= `AASA_RST_STATUS;
      ptr0_reg <= `AASA_RST_PTR;
      ptr1_reg <= `AASA_RST_PTR;
      mem_rd_reg <= 1'b0;
      mem_wr_reg <= 1'b0;
      mem_addr_reg <= `AASA_RST_ADDR;
      mem_wdata_reg <= `AASA_RST_BYTE;
      rdata_reg <= `AASA_RST_BYTE;
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      dest_reg <= dest_next;
      w_reg <= w_next;
      status_reg <= status_next;
      ptr0_reg <= ptr0_next;
      ptr1_reg <= ptr1_next;
      mem_rd_reg <= mem_rd_next;
      mem_wr_reg <= mem_wr_next;
      mem_addr_reg <= mem_addr_next;
      mem_wdata_reg <= mem_wdata_next;
      rdata_reg <= rdata_next;
    end
  end

  // Busy is the registered state, so a file op blocks issue for two cycles
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_busy <= 1'b0;
    end else begin
      o_busy <= (state_next != AASA_ST_IDLE);
    end
  end

  assign o_mem_rd = mem_rd_reg;
  assign o_mem_wr = mem_wr_reg;
  assign o_mem_addr = mem_addr_reg;
  assign o_mem_wdata = mem_wdata_reg;
  assign o_rdata = rdata_reg;
  assign o_w = w_reg;
  assign o_status = status_reg;
endmodule

// [test/aasa_alu_sva.sv]
// Port-level checker for the add-and-shift ALU.
// Assumes binding onto aasa_alu; one clock, async active-low reset.
`timescale 1ns/100ps
`include "aasa_map.svh"
module aasa_alu_sva (
  // Clock, reset, issue
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_instr_valid,
  input wire logic [13:0] i_instr,
  input wire logic [7:0] i_mem_rdata,
  // Results
  input wire logic o_busy,
  input wire logic o_mem_rd,
  input wire logic o_mem_wr,
  input wire logic [6:0] o_mem_addr,
  input wire logic [7:0] o_w,
  input wire logic [2:0] o_status
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  wire logic go = i_instr_valid && !o_busy;
  wire logic [5:0] op = i_instr[13:8];
  wire logic [7:0] lit = i_instr[7:0];
  wire logic [6:0] fa = i_instr[6:0];
  wire logic [3:0] wl = o_w[3:0];
  wire logic [3:0] ll = i_instr[3:0];
  wire logic dbit = i_instr[7];
  wire logic mb0 = i_mem_rdata[0];
  sequence s_file_go;
    go && (op == `AASA_OP_ADD_FILE || op == `AASA_OP_AND_FILE ||
      op == `AASA_OP_ADD_FILE_C || op == `AASA_OP_ASR_FILE);
  endsequence
  sequence s_file_walk;
    o_mem_rd && o_busy ##1 !o_mem_rd && o_busy ##1 !o_busy;
  endsequence
  a_file_walk: assert property (s_file_go |=> s_file_walk)
    else $error("file op handshake wrong");
  a_mem_addr: assert property (s_file_go |=> o_mem_addr == $past(fa))
    else $error("file address wrong");
  a_dest_sel: assert property (s_file_go |-> ##3 o_mem_wr == $past(dbit, 3))
    else $error("destination select wrong");
  a_addi_sum: assert property (go && op == `AASA_OP_ADD_IMM |=>
    {o_status[0], o_w} == $past(o_w) + $past(lit)) else $error("add sum wrong");
  a_addi_flags: assert property (go && op == `AASA_OP_ADD_IMM |=>
    o_status[1] == (($past(wl) + $past(ll)) > 5'hf) && o_status[2] == (o_w == 8'h00))
    else $error("add flags wrong");
  a_andi_result: assert property (go && op == `AASA_OP_AND_IMM |=>
    o_w == ($past(o_w) & $past(lit)) && $stable(o_status[1:0]) && o_status[2] == (o_w == 8'h00))
    else $error("and result wrong");
  a_ptr_flags: assert property (go && i_instr[13:7] == `AASA_PTR_PREFIX |=>
    $stable(o_status) && $stable(o_w)) else $error("pointer add touched flags");
  a_asr_carry: assert property (go && op == `AASA_OP_ASR_FILE |->
    ##3 o_status[0] == $past(mb0)) else $error("shift carry wrong");
endmodule
bind aasa_alu aasa_alu_sva chk_u (.i_clk(i_clk), .i_resetn(i_resetn),
  .i_instr_valid(i_instr_valid), .i_instr(i_instr), .i_mem_rdata(i_mem_rdata),
  .o_busy(o_busy), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr), .o_mem_addr(o_mem_addr),
  .o_w(o_w), .o_status(o_status));

// [test/testbench.sv]
// Self-checking bench for the add-and-shift ALU.
// Assumes aasa_alu and its checker are compiled first.
`timescale 1ns/100ps
module testbench;
  typedef struct {logic [13:0] ins; logic [7:0] w; logic [2:0] st;} aasa_lit_type;
  typedef struct {logic [5:0] op; logic d; logic [6:0] f;
    logic [7:0] w, m, r; logic [2:0] ps, st;} aasa_file_type;
  logic i_clk = 0, i_resetn = 0, i_instr_valid = 0, i_wr = 0, i_rd = 0;
  logic [13:0] i_instr = 0;
  logic [7:0] i_mem_rdata = 0, i_wdata = 0, o_rdata, o_w, o_mem_wdata;
  logic [3:0] i_addr = 0;
  logic [6:0] o_mem_addr;
  logic [2:0] o_status;
  logic o_busy, o_mem_rd, o_mem_wr;
  int n_errors = 0, checked = 0, cycles = 0;
  // W, then {Z,DC,C}, after each back-to-back literal op
  aasa_lit_type lits[10] = '{'{14'h3e0f, 8'h0f, 3'h0}, '{14'h3ef1, 8'h00, 3'h7},
    '{14'h39ff, 8'h00, 3'h7}, '{14'h3e80, 8'h80, 3'h0}, '{14'h397f, 8'h00, 3'h4},
    '{14'h3e08, 8'h08, 3'h0}, '{14'h3e08, 8'h10, 3'h2}, '{14'h391f, 8'h10, 3'h2},
    '{14'h317f, 8'h10, 3'h2}, '{14'h311f, 8'h10, 3'h2}};
  aasa_file_type fils[8] = '{
    '{6'h07, 1'h0, 7'h10, 8'h88, 8'h78, 8'h00, 3'h0, 3'h7},
    '{6'h07, 1'h1, 7'h7f, 8'h01, 8'h02, 8'h03, 3'h7, 3'h0},
    '{6'h05, 1'h0, 7'h00, 8'hf0, 8'h0f, 8'h00, 3'h3, 3'h7},
    '{6'h05, 1'h1, 7'h55, 8'h3c, 8'h0f, 8'h0c, 3'h0, 3'h0},
    '{6'h3d, 1'h0, 7'h01, 8'hff, 8'h00, 8'h00, 3'h1, 3'h7},
    '{6'h3d, 1'h1, 7'h01, 8'h10, 8'h20, 8'h30, 3'h0, 3'h0},
    '{6'h37, 1'h0, 7'h12, 8'h00, 8'h81, 8'hc0, 3'h2, 3'h3},
    '{6'h37, 1'h1, 7'h12, 8'h00, 8'h01, 8'h00, 3'h0, 3'h5}};
  aasa_alu dut_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_instr_valid(i_instr_valid),
    .i_instr(i_instr), .o_busy(o_busy), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr),
    .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .i_mem_rdata(i_mem_rdata),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_w(o_w), .o_status(o_status));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    if (n_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'h1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_rd <= 1'h1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'h0;
    #1 chk(o_rdata, e);
  endtask
  task automatic ptr(input int n, input logic [15:0] e);
    rd(4'(2 + 2 * n), e[7:0]);
    rd(4'(3 + 2 * n), e[15:8]);
  endtask
  task automatic issue(input logic [13:0] x);
    @(posedge i_clk);
    i_instr_valid <= 1'h1;
    i_instr <= x;
    @(posedge i_clk);
    i_instr_valid <= 1'h0;
  endtask
  always #50 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      stop_test;
    end
  end
  initial begin
    repeat (5) @(posedge i_clk);
    i_resetn <= 1'h1;
    #1 chk({o_w, 5'h0, o_status}, 16'h0);
    for (int i = 0; i <= 10; i++) begin
      @(posedge i_clk);
      i_instr_valid <= (i < 10);
      if (i < 10) i_instr <= lits[i].ins;
      if (i > 0) begin
        @(negedge i_clk);
        chk({o_w, 5'h0, o_status}, {lits[i-1].w, 5'h0, lits[i-1].st});
      end
    end
    ptr(0, 16'h001f);
    ptr(1, 16'hffff);
    rd(4'h1, 8'h02);
    rd(4'hf, 8'h00);
    issue(14'h3141);
    issue(14'h3120);
    ptr(1, 16'h0000);
    ptr(0, 16'hffff);
    foreach (fils[i]) begin
      wr(4'h0, fils[i].w);
      wr(4'h1, {5'h0, fils[i].ps});
      @(posedge i_clk);
      i_instr_valid <= 1'h1;
      i_instr <= {fils[i].op, fils[i].d, fils[i].f};
      i_mem_rdata <= fils[i].m;
      @(posedge i_clk);
      i_instr_valid <= 1'h0;
      #1 chk({o_busy, o_mem_rd, o_mem_addr}, {2'h3, fils[i].f});
      repeat (2) @(posedge i_clk);
      #1 chk(fils[i].d ? o_mem_wdata : o_w, fils[i].r);
      chk({o_mem_wr, o_status}, {fils[i].d, fils[i].st});
      chk(o_w, fils[i].d ? fils[i].w : fils[i].r);
    end
    wr(4'h0, 8'h5a);
    // Literal op offered while a file op is busy must be dropped
    @(posedge i_clk);
    i_instr_valid <= 1'h1;
    i_instr <= {6'h07, 1'h1, 7'h20};
    i_mem_rdata <= 8'h01;
    @(posedge i_clk);
    i_instr <= 14'h3e01;
    @(posedge i_clk);
    i_instr_valid <= 1'h0;
    @(posedge i_clk);
    #1 chk({o_mem_wr, o_mem_wdata}, {1'h1, 8'h5b});
    chk({o_w, 5'h0, o_status}, {8'h5a, 5'h0, 3'h0});
    @(posedge i_clk);
    i_resetn <= 1'h0;
    @(posedge i_clk);
    #1 chk({o_w, 5'h0, o_status}, 16'h0);
    @(posedge i_clk);
    i_resetn <= 1'h1;
    ptr(0, 16'h0000);
    stop_test;
  end
endmodule
